//--- src/sltpg_pkg.sv
/*
  Constants, register map and mode codes of the serial link test pattern generator.
  Assumes one clock domain (the link clock) and byte-wide configuration access.
// How it works
// R1: transport sample test sends raw converter samples
// R2: four-bit selector picks the interface pattern
// R3: two-bit selector picks sample, symbol or octet point
// R4: codes 0011/0100 give 31- and 23-bit prbs
// R5: codes 0101-0111 give 15-, 9-, 7-bit prbs
// R6: ramp adds one per word, wraps at width
// R7: repeating user mode cycles four words forever
// R8: single user mode sends four words, then zeros
// R9: sample point: all frame samples share one word
// R10: symbol point advances per ten-bit symbol
// R11: octet point advances per octet
// R12: link-layer test selector inserts link test sequences
// R13: host disables sync input before link-layer tests
// R14: host soft reset returns to normal operation
// R15: prbs reloads its seed on new mode selection
*/
package sltpg_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_IF_CFG     = 16'h0000;
  localparam logic [15:0] ADDR_USER_FIRST = 16'h0551;
  localparam logic [15:0] ADDR_USER_LAST  = 16'h0558;
  localparam logic [15:0] ADDR_TPL        = 16'h0571;
  localparam logic [15:0] ADDR_LINK       = 16'h0572;
  localparam logic [15:0] ADDR_ITM        = 16'h0573;
  localparam logic [15:0] ADDR_DLL        = 16'h0574;
  localparam logic [7:0]  SOFT_RST_VAL    = 8'h81;
  localparam logic [7:0]  REG_RST_VAL     = 8'h00;
  localparam int          TPL_EN_BIT      = 5;
  localparam logic [7:0]  ITM_MASK        = 8'h3F;
  localparam logic [7:0]  DLL_MASK        = 8'h07;
  localparam logic [1:0]  SYNC_OFF_CODE   = 2'h3;
  // ==========================================================
  // pattern constants
  localparam logic [15:0] CHK_WORD    = 16'h5555;
  localparam logic [15:0] ONES_WORD   = 16'hFFFF;
  localparam logic [7:0]  KCHAR_OCT   = 8'hBC;
  localparam logic [4:0]  W_SAMPLE    = 5'h10;
  localparam logic [4:0]  W_SYMBOL    = 5'h0A;
  localparam logic [4:0]  W_OCTET     = 5'h08;
  localparam int          PRBS_MAX    = 31;
  localparam int          STEP_MAX    = 16;
  localparam logic [30:0] SEED_PN31   = 31'h0003AFFF;
  localparam logic [30:0] SEED_PRBS_TWENTYTHREE_BIT_PATTERN   = 31'h00003AFF;
  localparam logic [30:0] SEED_PN15   = 31'h000003AF;
  localparam logic [30:0] SEED_PN9    = 31'h00000092;
  localparam logic [30:0] SEED_PN7    = 31'h00000007;
  localparam int PN31_A = 30, PN31_B = 27, PRBS_TWENTYTHREE_BIT_PATTERN_A = 22, PRBS_TWENTYTHREE_BIT_PATTERN_B = 17;
  localparam int PN15_A = 14, PN15_B = 13, PN9_A = 8, PN9_B = 4;
  localparam int PN7_A = 6, PN7_B = 5;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    SLTPG_OFF      = 4'b0000,
    SLTPG_CHECKER  = 4'b0001,
    SLTPG_TOGGLE   = 4'b0010,
    SLTPG_PN31     = 4'b0011,
    SLTPG_PRBS_TWENTYTHREE_BIT_PATTERN     = 4'b0100,
    SLTPG_PN15     = 4'b0101,
    SLTPG_PN9      = 4'b0110,
    SLTPG_PN7      = 4'b0111,
    SLTPG_RAMP     = 4'b1000,
    SLTPG_USER_REP = 4'b1110,
    SLTPG_USER_ONE = 4'b1111
  } sltpg_mode_e;
  typedef enum logic [1:0] {
    SLTPG_PT_SAMPLE = 2'b00,
    SLTPG_PT_SYMBOL = 2'b01,
    SLTPG_PT_OCTET  = 2'b10,
    SLTPG_PT_NONE   = 2'b11
  } sltpg_point_e;
  localparam logic [2:0] DLL_KCHAR = 3'h1;
endpackage

//--- src/sltpg_prbs.sv
/*
  Pseudorandom generator for the five interface prbs modes, nbits bits per step.
  Assumes load and step come from logic on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sltpg_prbs (
  input wire logic     sys_clk,
  input wire logic     rst,
  input wire logic     ce,
  sltpg_prbs_if.gen    pif
);
  logic [30:0] state_q;
  logic [30:0] state_d;
  logic [15:0] word;

  function automatic logic fb_bit(logic [30:0] s, sltpg_pkg::sltpg_mode_e m);
    case (m)
      sltpg_pkg::SLTPG_PN31: fb_bit = s[sltpg_pkg::PN31_A] ^ s[sltpg_pkg::PN31_B]; // see R4
      sltpg_pkg::SLTPG_PRBS_TWENTYTHREE_BIT_PATTERN: fb_bit = s[sltpg_pkg::PRBS_TWENTYTHREE_BIT_PATTERN_A] ^ s[sltpg_pkg::PRBS_TWENTYTHREE_BIT_PATTERN_B]; // see R4
      sltpg_pkg::SLTPG_PN15: fb_bit = s[sltpg_pkg::PN15_A] ^ s[sltpg_pkg::PN15_B]; // see R5
      sltpg_pkg::SLTPG_PN9:  fb_bit = s[sltpg_pkg::PN9_A] ^ s[sltpg_pkg::PN9_B];   // see R5
      sltpg_pkg::SLTPG_PN7:  fb_bit = s[sltpg_pkg::PN7_A] ^ s[sltpg_pkg::PN7_B];   // see R5
      default:               fb_bit = 1'b0;
    endcase
  endfunction

  // top tap: the oldest bit, which is also the bit sent next
  function automatic int hi_of(sltpg_pkg::sltpg_mode_e m);
    case (m)
      sltpg_pkg::SLTPG_PN31: hi_of = sltpg_pkg::PN31_A;
      sltpg_pkg::SLTPG_PRBS_TWENTYTHREE_BIT_PATTERN: hi_of = sltpg_pkg::PRBS_TWENTYTHREE_BIT_PATTERN_A;
      sltpg_pkg::SLTPG_PN15: hi_of = sltpg_pkg::PN15_A;
      sltpg_pkg::SLTPG_PN9:  hi_of = sltpg_pkg::PN9_A;
      sltpg_pkg::SLTPG_PN7:  hi_of = sltpg_pkg::PN7_A;
      default:               hi_of = 0;
    endcase
  endfunction

  // seed lsb goes out first, so it is loaded mirrored into the top tap
  function automatic logic [30:0] seed_of(sltpg_pkg::sltpg_mode_e m);
    logic [30:0] raw;
    case (m)
      sltpg_pkg::SLTPG_PN31: raw = sltpg_pkg::SEED_PN31;
      sltpg_pkg::SLTPG_PRBS_TWENTYTHREE_BIT_PATTERN: raw = sltpg_pkg::SEED_PRBS_TWENTYTHREE_BIT_PATTERN;
      sltpg_pkg::SLTPG_PN15: raw = sltpg_pkg::SEED_PN15;
      sltpg_pkg::SLTPG_PN9:  raw = sltpg_pkg::SEED_PN9;
      sltpg_pkg::SLTPG_PN7:  raw = sltpg_pkg::SEED_PN7;
      default:               raw = '0;
    endcase
    seed_of = '0;
    for (int i = 0; i < sltpg_pkg::PRBS_MAX; i++) begin
      if (i <= hi_of(m)) begin
        seed_of[hi_of(m) - i] = raw[i];
      end
    end
  endfunction

  // bits above the polynomial degree are never tapped, so no mask is needed
  always_comb begin
    state_d = state_q;
    word    = '0;
    for (int i = 0; i < sltpg_pkg::STEP_MAX; i++) begin
      if (5'(i) < pif.nbits) begin
        word    = {word[14:0], state_d[hi_of(pif.mode)]}; // see R4
        state_d = {state_d[29:0], fb_bit(state_d, pif.mode)};
      end
    end
  end
  assign pif.word = word;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      if (pif.load) begin
        state_q <= seed_of(pif.mode); // see R15
      end else if (pif.step) begin
        state_q <= state_d;
      end
    end
  end

  property p_seed_load;
    @(posedge sys_clk) disable iff (rst)
    (ce && pif.load) |=> (state_q == seed_of($past(pif.mode)));
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("prbs seed not loaded"); // see R15
endmodule
`default_nettype wire

//--- src/sltpg_prbs_if.sv
/*
  Carrier between the pattern sequencer and the prbs generator.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sltpg_prbs_if;
  sltpg_pkg::sltpg_mode_e mode;
  logic                   load;
  logic                   step;
  logic [4:0]             nbits;
  logic [15:0]            word;
  modport gen  (input mode, input load, input step, input nbits, output word);
  modport user (output mode, output load, output step, output nbits, input word);
endinterface
`default_nettype wire

//--- src/sltpg_top.sv
/*
  Test pattern generator for the serial link transmit path: register file,
  pattern sequencer and injection at sample, symbol or octet point.
  Assumes byte register access from the configuration port on sys_clk and
  stream inputs with one-cycle valid strobes on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sltpg_top #(
  parameter int NUM_CONV       = 2,
  parameter int SAMP_PER_FRAME = 2,
  parameter int SAMP_W         = 16
) (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst,
  input  wire logic                                       ce,
  input  wire logic [15:0]                                reg_addr,
  input  wire logic [7:0]                                 reg_wdata,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  output logic [7:0]                                      reg_rdata,
  input  wire logic [NUM_CONV*SAMP_PER_FRAME*SAMP_W-1:0]  samp_in,
  input  wire logic                                       samp_vld_in,
  output logic [NUM_CONV*SAMP_PER_FRAME*SAMP_W-1:0]       samp_out,
  output logic                                            samp_vld_out,
  output logic                                            tpl_test_active,
  input  wire logic [9:0]                                 sym_in,
  input  wire logic                                       sym_vld_in,
  output logic [9:0]                                      sym_out,
  output logic                                            sym_vld_out,
  input  wire logic [7:0]                                 oct_in,
  input  wire logic                                       oct_vld_in,
  output logic [7:0]                                      oct_out,
  output logic                                            oct_k_out,
  output logic                                            oct_vld_out,
  output logic [2:0]                                      dll_test_sel,
  input  wire logic                                       link_sync_request_input,
  output logic                                            sync_request_out
);
  localparam int NSAMP = NUM_CONV * SAMP_PER_FRAME;

  if (SAMP_W != 16 || NSAMP < 1) begin : g_bad_cfg
    $error("sltpg_top: sample width must be 16 and at least one sample");
  end

  // ==========================================================
  // register file
  logic [7:0]  tpl_q;
  logic [7:0]  link_q;
  logic [7:0]  itm_q;
  logic [7:0]  dll_q;
  logic [7:0]  user_q [8];
  logic        soft_rst;

  // soft reset clears every test selection in one go
  assign soft_rst = reg_wr && reg_addr == sltpg_pkg::ADDR_IF_CFG
                    && (reg_wdata & sltpg_pkg::SOFT_RST_VAL) == sltpg_pkg::SOFT_RST_VAL;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tpl_q  <= sltpg_pkg::REG_RST_VAL;
      link_q <= sltpg_pkg::REG_RST_VAL;
      itm_q  <= sltpg_pkg::REG_RST_VAL;
      dll_q  <= sltpg_pkg::REG_RST_VAL;
      for (int i = 0; i < 8; i++) begin
        user_q[i] <= sltpg_pkg::REG_RST_VAL;
      end
    end else if (ce) begin
      if (soft_rst) begin
        tpl_q <= sltpg_pkg::REG_RST_VAL;
        itm_q <= sltpg_pkg::REG_RST_VAL;
        dll_q <= sltpg_pkg::REG_RST_VAL;
      end else if (reg_wr) begin
        case (reg_addr)
          sltpg_pkg::ADDR_TPL:  tpl_q  <= reg_wdata;
          sltpg_pkg::ADDR_LINK: link_q <= reg_wdata;
          sltpg_pkg::ADDR_ITM:  itm_q  <= reg_wdata & sltpg_pkg::ITM_MASK;
          sltpg_pkg::ADDR_DLL:  dll_q  <= reg_wdata & sltpg_pkg::DLL_MASK;
          default: begin
            if (reg_addr >= sltpg_pkg::ADDR_USER_FIRST && reg_addr <= sltpg_pkg::ADDR_USER_LAST) begin
              user_q[3'(reg_addr - sltpg_pkg::ADDR_USER_FIRST)] <= reg_wdata;
            end
          end
        endcase
      end
    end
  end

  // interface config byte reads zero: its reset bits clear themselves
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        sltpg_pkg::ADDR_TPL:  reg_rdata <= tpl_q;
        sltpg_pkg::ADDR_LINK: reg_rdata <= link_q;
        sltpg_pkg::ADDR_ITM:  reg_rdata <= itm_q;
        sltpg_pkg::ADDR_DLL:  reg_rdata <= dll_q;
        default: begin
          if (reg_addr >= sltpg_pkg::ADDR_USER_FIRST && reg_addr <= sltpg_pkg::ADDR_USER_LAST) begin
            reg_rdata <= user_q[3'(reg_addr - sltpg_pkg::ADDR_USER_FIRST)];
          end else begin
            reg_rdata <= '0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // sync request input: pin crosses two flops, host may mask it
  logic sync_meta_q;
  logic sync_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_meta_q <= 1'b0;
      sync_q      <= 1'b0;
    end else if (ce) begin
      sync_meta_q <= link_sync_request_input;
      sync_q      <= sync_meta_q;
    end
  end
  assign sync_request_out = sync_q && (link_q[7:6] != sltpg_pkg::SYNC_OFF_CODE); // see R13

  // ==========================================================
  // pattern sequencer
  sltpg_pkg::sltpg_mode_e  mode;
  sltpg_pkg::sltpg_point_e point;
  logic [5:0]  prev_cfg_q;
  logic        restart;
  logic        step;
  logic        phase_q;
  logic [15:0] ramp_q;
  logic [1:0]  up_idx_q;
  logic        up_done_q;
  logic [15:0] up_word;
  logic [15:0] pat;
  logic        tpl_en;

  assign mode    = sltpg_pkg::sltpg_mode_e'(itm_q[3:0]); // see R2
  assign point   = sltpg_pkg::sltpg_point_e'(itm_q[5:4]); // see R3
  assign tpl_en  = tpl_q[sltpg_pkg::TPL_EN_BIT];
  assign restart = ce && (itm_q[5:0] != prev_cfg_q);
  assign up_word = {user_q[{up_idx_q, 1'b1}], user_q[{up_idx_q, 1'b0}]};

  // one step per word at the chosen point
  always_comb begin
    case (point)
      sltpg_pkg::SLTPG_PT_SAMPLE: step = ce && samp_vld_in; // see R9
      sltpg_pkg::SLTPG_PT_SYMBOL: step = ce && sym_vld_in;  // see R10
      sltpg_pkg::SLTPG_PT_OCTET:  step = ce && oct_vld_in;  // see R11
      default:                    step = 1'b0;
    endcase
    if (mode == sltpg_pkg::SLTPG_OFF) begin
      step = 1'b0;
    end
  end

  sltpg_prbs_if prbs_bus ();
  assign prbs_bus.mode  = mode;
  assign prbs_bus.load  = restart; // see R15
  assign prbs_bus.step  = step;
  assign prbs_bus.nbits = point == sltpg_pkg::SLTPG_PT_SAMPLE ? sltpg_pkg::W_SAMPLE :
                          point == sltpg_pkg::SLTPG_PT_SYMBOL ? sltpg_pkg::W_SYMBOL :
                          sltpg_pkg::W_OCTET;

  sltpg_prbs u_prbs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pif     (prbs_bus)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_cfg_q <= '0;
      phase_q    <= 1'b0;
      ramp_q     <= '0;
      up_idx_q   <= '0;
      up_done_q  <= 1'b0;
    end else if (ce) begin
      prev_cfg_q <= itm_q[5:0];
      if (restart) begin
        phase_q   <= 1'b0;
        ramp_q    <= '0;
        up_idx_q  <= '0;
        up_done_q <= 1'b0;
      end else if (step) begin
        phase_q  <= ~phase_q;
        ramp_q   <= ramp_q + 16'h0001; // see R6
        up_idx_q <= up_idx_q + 2'h1;   // see R7
        if (up_idx_q == 2'h3) begin
          up_done_q <= 1'b1;           // see R8
        end
      end
    end
  end

  // word in low bits; wider bits are dropped at the narrower points, except in user modes, whose top bits are shifted down
  always_comb begin
    case (mode)
      sltpg_pkg::SLTPG_CHECKER:  pat = phase_q ? ~sltpg_pkg::CHK_WORD : sltpg_pkg::CHK_WORD;
      sltpg_pkg::SLTPG_TOGGLE:   pat = phase_q ? sltpg_pkg::ONES_WORD : '0;
      sltpg_pkg::SLTPG_PN31,
      sltpg_pkg::SLTPG_PRBS_TWENTYTHREE_BIT_PATTERN,
      sltpg_pkg::SLTPG_PN15,
      sltpg_pkg::SLTPG_PN9,
      sltpg_pkg::SLTPG_PN7:      pat = prbs_bus.word;
      sltpg_pkg::SLTPG_RAMP:     pat = ramp_q;
      sltpg_pkg::SLTPG_USER_REP,
      sltpg_pkg::SLTPG_USER_ONE: pat = up_done_q && mode == sltpg_pkg::SLTPG_USER_ONE ? '0 : up_word;
      default:                   pat = '0;
    endcase
    if (mode == sltpg_pkg::SLTPG_USER_REP || mode == sltpg_pkg::SLTPG_USER_ONE) begin
      case (point)
        sltpg_pkg::SLTPG_PT_SYMBOL: pat = {6'h00, pat[15:6]};        // see R10
        sltpg_pkg::SLTPG_PT_OCTET:  pat = {8'h00, pat[15:9], 1'b0};  // see R11
        default:                    pat = pat;
      endcase
    end
  end

  // ==========================================================
  // injection and output registers
  assign dll_test_sel    = dll_q[2:0]; // see R12
  assign tpl_test_active = tpl_en;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_out     <= '0;
      samp_vld_out <= 1'b0;
    end else if (ce) begin
      samp_vld_out <= samp_vld_in;
      if (samp_vld_in) begin
        // transport test samples are the raw samples themselves
        samp_out <= samp_in; // see R1
        if (point == sltpg_pkg::SLTPG_PT_SAMPLE && mode != sltpg_pkg::SLTPG_OFF) begin
          samp_out <= {NSAMP{pat}}; // see R9
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sym_out     <= '0;
      sym_vld_out <= 1'b0;
    end else if (ce) begin
      sym_vld_out <= sym_vld_in;
      if (sym_vld_in) begin
        sym_out <= (point == sltpg_pkg::SLTPG_PT_SYMBOL && mode != sltpg_pkg::SLTPG_OFF)
                   ? pat[9:0] : sym_in; // see R10
      end
    end
  end

  // link-layer k-character fill overrides the octet stream
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oct_out     <= '0;
      oct_k_out   <= 1'b0;
      oct_vld_out <= 1'b0;
    end else if (ce) begin
      oct_vld_out <= oct_vld_in;
      if (oct_vld_in) begin
        oct_k_out <= dll_q[2:0] == sltpg_pkg::DLL_KCHAR; // see R12
        if (dll_q[2:0] == sltpg_pkg::DLL_KCHAR) begin
          oct_out <= sltpg_pkg::KCHAR_OCT;
        end else if (point == sltpg_pkg::SLTPG_PT_OCTET && mode != sltpg_pkg::SLTPG_OFF) begin
          oct_out <= pat[7:0]; // see R11
        end else begin
          oct_out <= oct_in;
        end
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_ramp_oct;
    ce && oct_vld_in && !restart && dll_q[2:0] != sltpg_pkg::DLL_KCHAR
    && mode == sltpg_pkg::SLTPG_RAMP && point == sltpg_pkg::SLTPG_PT_OCTET;
  endsequence
  sequence s_chk_sym;
    ce && sym_vld_in && !restart && mode == sltpg_pkg::SLTPG_CHECKER
    && point == sltpg_pkg::SLTPG_PT_SYMBOL;
  endsequence

  property p_raw_samples;
    @(posedge sys_clk) disable iff (rst)
    (ce && samp_vld_in && tpl_en && mode == sltpg_pkg::SLTPG_OFF) |=> samp_out == $past(samp_in);
  endproperty
  a_raw_samples: assert property (p_raw_samples) else $error("raw samples not passed"); // see R1

  property p_off_oct;
    @(posedge sys_clk) disable iff (rst)
    (ce && oct_vld_in && mode == sltpg_pkg::SLTPG_OFF && dll_q == '0) |=> oct_out == $past(oct_in);
  endproperty
  a_off_oct: assert property (p_off_oct) else $error("octet changed while off"); // see R2

  property p_ramp_oct;
    @(posedge sys_clk) disable iff (rst)
    (s_ramp_oct ##1 s_ramp_oct) |=> oct_out == 8'($past(oct_out) + 8'h01);
  endproperty
  a_ramp_oct: assert property (p_ramp_oct) else $error("ramp did not advance by one"); // see R6

  property p_chk_sym;
    @(posedge sys_clk) disable iff (rst)
    (s_chk_sym ##1 s_chk_sym) |=> sym_out == ~$past(sym_out) && (sym_out == 10'h155 || sym_out == 10'h2AA);
  endproperty
  a_chk_sym: assert property (p_chk_sym) else $error("symbol checkerboard wrong"); // see R10

  property p_toggle_samp;
    @(posedge sys_clk) disable iff (rst)
    (step && mode == sltpg_pkg::SLTPG_TOGGLE && point == sltpg_pkg::SLTPG_PT_SAMPLE)
    |=> samp_out == {NSAMP{samp_out[15:0]}} && (samp_out[15:0] == 16'h0000 || samp_out[15:0] == 16'hFFFF);
  endproperty
  a_toggle_samp: assert property (p_toggle_samp) else $error("frame samples differ"); // see R9

  property p_user_wrap;
    @(posedge sys_clk) disable iff (rst)
    (step && !restart && up_idx_q == 2'h3) |=> up_idx_q == 2'h0 ##0 up_done_q;
  endproperty
  a_user_wrap: assert property (p_user_wrap) else $error("user index did not wrap"); // see R7

  property p_user_zero;
    @(posedge sys_clk) disable iff (rst)
    (step && !restart && up_done_q && mode == sltpg_pkg::SLTPG_USER_ONE
     && dll_q[2:0] != sltpg_pkg::DLL_KCHAR)
    |=> (($past(point) == sltpg_pkg::SLTPG_PT_SAMPLE) ? (samp_out == '0)
         : ($past(point) == sltpg_pkg::SLTPG_PT_SYMBOL) ? (sym_out == '0) : (oct_out == '0));
  endproperty
  a_user_zero: assert property (p_user_zero) else $error("single user not zero"); // see R8

  property p_kchar;
    @(posedge sys_clk) disable iff (rst)
    (ce && oct_vld_in && dll_q[2:0] == sltpg_pkg::DLL_KCHAR) |=> oct_k_out && oct_out == 8'hBC;
  endproperty
  a_kchar: assert property (p_kchar) else $error("k character not inserted"); // see R12

  property p_point_sym;
    @(posedge sys_clk) disable iff (rst)
    (ce && sym_vld_in && point != sltpg_pkg::SLTPG_PT_SYMBOL) |=> sym_out == $past(sym_in);
  endproperty
  a_point_sym: assert property (p_point_sym) else $error("symbol altered at wrong point"); // see R3
endmodule
`default_nettype wire

//--- tb/sltpg_rx_model.sv
/*
  Receiver-side model: shows the word of the selected injection point and
  drives the sync request pin.
  Assumes the stream outputs of sltpg_top on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sltpg_rx_model (
  input  wire logic [1:0]  pt,
  input  wire logic        want_sync,
  input  wire logic [63:0] samp,
  input  wire logic        samp_vld,
  input  wire logic [9:0]  sym,
  input  wire logic        sym_vld,
  input  wire logic [7:0]  oct,
  input  wire logic        oct_vld,
  output logic             sync_req,
  output logic [63:0]      rx_word,
  output logic             rx_vld
);
  // ==========================================================
  // sync request is a level held by the receiver until it has lock
  assign sync_req = want_sync;
  assign rx_word  = (pt == 2'h0) ? samp : (pt == 2'h1) ? {54'h0, sym} : {56'h0, oct};
  assign rx_vld   = (pt == 2'h0) ? samp_vld : (pt == 2'h1) ? sym_vld : oct_vld;
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench of the test pattern generator: register tasks and stream runs.
  Assumes sltpg_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, vld = 1'b0, want = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h0, rdata, reg_rdata, oct_out;
  logic [63:0] samp_in = 64'h1234_5678_9ABC_DEF0, samp_out, rx_word, got[5];
  logic [9:0]  sym_out;
  logic [2:0]  dll_test_sel;
  logic [1:0]  pt = 2'h0;
  logic [19:0] w1;
  logic samp_vld_out, sym_vld_out, oct_vld_out, oct_k_out, tpl_test_active;
  logic sync_pin, sync_request_out, rx_vld, ce = 1'b1;
  logic [15:0] up[4] = '{16'hA5C3, 16'h1E69, 16'hF00F, 16'h3C96};
  int miscompares = 0, total_checks = 0;
  initial forever #5 sys_clk = ~sys_clk;
  sltpg_top dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_in(samp_in), .samp_vld_in(vld && pt == 2'h0), .samp_out(samp_out),
    .samp_vld_out(samp_vld_out), .tpl_test_active(tpl_test_active),
    .sym_in(10'h0F0), .sym_vld_in(vld && pt == 2'h1), .sym_out(sym_out),
    .sym_vld_out(sym_vld_out), .oct_in(8'h3C), .oct_vld_in(vld && pt == 2'h2),
    .oct_out(oct_out), .oct_k_out(oct_k_out), .oct_vld_out(oct_vld_out),
    .dll_test_sel(dll_test_sel), .link_sync_request_input(sync_pin),
    .sync_request_out(sync_request_out));
  sltpg_rx_model rx (.pt(pt), .want_sync(want), .samp(samp_out), .samp_vld(samp_vld_out),
    .sym(sym_out), .sym_vld(sym_vld_out), .oct(oct_out), .oct_vld(oct_vld_out),
    .sync_req(sync_pin), .rx_word(rx_word), .rx_vld(rx_vld));
  // ==========================================================
  // register access and stream tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    // idle cycle: pattern restart lands before the first valid
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    `CHK("reg", e, reg_rdata)
  endtask
  task automatic send(input int n);
    @(negedge sys_clk);
    vld = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      got[i] = rx_word;
      `CHK("vld", 1'b1, rx_vld)
      if (i == n - 1) vld = 1'b0;
    end
  endtask
  task automatic run(input logic [7:0] itm, input logic [15:0] e[5]);
    logic [63:0] x;
    pt = itm[5:4];
    wr(sltpg_pkg::ADDR_ITM, itm);
    send(5);
    for (int i = 0; i < 5; i++) begin
      x = (pt == 2'h0) ? {4{e[i]}} : (pt == 2'h1) ? {54'h0, e[i][9:0]} : {56'h0, e[i][7:0]};
      `CHK("word", x, got[i])
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    rd(sltpg_pkg::ADDR_TPL, 8'h00); rd(sltpg_pkg::ADDR_ITM, 8'h00); rd(sltpg_pkg::ADDR_DLL, 8'h00);
    wr(sltpg_pkg::ADDR_ITM, 8'hFF); rd(sltpg_pkg::ADDR_ITM, 8'h3F);
    wr(sltpg_pkg::ADDR_DLL, 8'hFF); rd(sltpg_pkg::ADDR_DLL, 8'h07);
    `CHK("dll_sel", 3'h7, dll_test_sel)
    wr(16'h0600, 8'h5A); rd(16'h0600, 8'h00);
    ce = 1'b0; wr(sltpg_pkg::ADDR_TPL, 8'h20); ce = 1'b1;
    rd(sltpg_pkg::ADDR_TPL, 8'h00);
    wr(sltpg_pkg::ADDR_DLL, 8'h00); wr(sltpg_pkg::ADDR_ITM, 8'h00);
    wr(sltpg_pkg::ADDR_TPL, 8'h20); rd(sltpg_pkg::ADDR_TPL, 8'h20);
    `CHK("tpl", 1'b1, tpl_test_active)
    send(1);
    `CHK("raw", samp_in, got[0])
    `CHK("sync_on", 1'b1, sync_request_out)
    run(8'h11, '{16'h155, 16'h2AA, 16'h155, 16'h2AA, 16'h155});
    run(8'h12, '{16'h000, 16'h3FF, 16'h000, 16'h3FF, 16'h000});
    run(8'h21, '{16'h55, 16'hAA, 16'h55, 16'hAA, 16'h55});
    run(8'h22, '{16'h00, 16'hFF, 16'h00, 16'hFF, 16'h00});
    run(8'h01, '{16'h5555, 16'hAAAA, 16'h5555, 16'hAAAA, 16'h5555});
    run(8'h02, '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000});
    run(8'h08, '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4});
    run(8'h18, '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4});
    run(8'h28, '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4});
    run(8'h16, '{16'h125, 16'h2FC, 16'h26A, 16'h198, 16'h031});
    run(8'h14, '{16'h3FD, 16'h1C0, 16'h00A, 16'h1B8, 16'h028});
    run(8'h26, '{16'h49, 16'h6F, 16'hC9, 16'hA9, 16'h98});
    run(8'h06, '{16'h496F, 16'hC9A9, 16'h980C, 16'h651A, 16'h5FD1});
    run(8'h04, '{16'hFF5C, 16'h0029, 16'hB80A, 16'h3D72, 16'h9B26});
    pt = 2'h1;
    for (int c = 3; c < 8; c += 2) begin
      wr(sltpg_pkg::ADDR_ITM, 8'h10 | 8'(c));
      send(2);
      w1 = {got[0][9:0], got[1][9:0]};
      wr(sltpg_pkg::ADDR_ITM, 8'h11);
      wr(sltpg_pkg::ADDR_ITM, 8'h10 | 8'(c));
      send(2);
      `CHK("reseed", w1, {got[0][9:0], got[1][9:0]})
    end
    for (int n = 0; n < 4; n++) begin
      wr(16'h0551 + 16'(2 * n), up[n][7:0]);
      wr(16'h0552 + 16'(2 * n), up[n][15:8]);
    end
    run(8'h0E, '{up[0], up[1], up[2], up[3], up[0]});
    run(8'h1F, '{up[0] >> 6, up[1] >> 6, up[2] >> 6, up[3] >> 6, 16'h0});
    wr(sltpg_pkg::ADDR_IF_CFG, 8'h81);
    rd(sltpg_pkg::ADDR_ITM, 8'h00); rd(sltpg_pkg::ADDR_TPL, 8'h00);
    want = 1'b0; repeat (3) @(negedge sys_clk);
    `CHK("sync_low", 1'b0, sync_request_out)
    want = 1'b1; repeat (3) @(negedge sys_clk);
    wr(sltpg_pkg::ADDR_LINK, 8'hC0);
    repeat (3) @(negedge sys_clk);
    `CHK("sync_off", 1'b0, sync_request_out)
    wr(sltpg_pkg::ADDR_DLL, 8'h01);
    pt = 2'h2;
    send(1);
    `CHK("kchar", {1'b1, 8'hBC}, {oct_k_out, got[0][7:0]})
    give_verdict();
  end
  // ==========================================================
  // watchdog: whole run is a few hundred cycles
  initial begin
    #500us;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
